// file: hw/itr_pkg.sv
// itr_pkg: routing block constants
package itr_pkg;
   // =====================================================================
   // source counts
   localparam int NUM_IRQ    = 8;                  // external request lines
   localparam int NUM_INT    = 52;                 // internal sources
   localparam int NUM_SRC    = NUM_IRQ + NUM_INT;  // maskable sources
   localparam int NUM_MOD    = 15;                 // priority groups
   localparam int SRC_PER_MOD = 4;                 // sources per group
   localparam int NUM_DMA    = 4;                  // dma channels
   localparam int NMI_LEVEL  = 8;                  // nmi fixed level
   // =====================================================================
   // register byte offsets
   localparam logic [7:0] OFF_SYSCTL = 8'h00;  // system_control_reg
   localparam logic [7:0] OFF_SENSE  = 8'h04;  // request line sense
   localparam logic [7:0] OFF_IRQEN  = 8'h08;  // request line enables
   localparam logic [7:0] OFF_IRQST  = 8'h0C;  // request flags, w1c
   localparam logic [7:0] OFF_PRIA   = 8'h10;  // priority_level_regs 0-7
   localparam logic [7:0] OFF_PRIB   = 8'h14;  // priority_level_regs 8-14
   localparam logic [7:0] OFF_TENLO  = 8'h18;  // transfer_enable_regs, low
   localparam logic [7:0] OFF_TENHI  = 8'h1C;  // transfer_enable_regs, high
   localparam logic [7:0] OFF_DMACTL = 8'h20;  // dma_channel_control_reg set
   localparam logic [7:0] OFF_STATUS = 8'h24;  // routing state, read only
   // =====================================================================
   // field positions
   localparam int SYS_MODE_LO = 0;  // control_mode_select_lo
   localparam int SYS_MODE_HI = 1;  // control_mode_select_hi
   localparam int SYS_NMI_RISE = 2; // nmi rising edge
   localparam int DMA_FLD_W   = 8;  // bits per dma channel
   localparam int DMA_CLAIM   = 4;  // dma_source_claim_bit
   localparam int PRI_FLD_W   = 4;  // bits per priority group
   // =====================================================================
   // encodings
   localparam logic [1:0] MODE_MASKBIT = 2'h0;  // one mask bit mode
   localparam logic [1:0] MODE_LEVEL   = 2'h2;  // level mask mode
   localparam logic [1:0] SENSE_LEVEL  = 2'h0;  // low level
   localparam logic [1:0] SENSE_FALL   = 2'h1;  // falling edge
   localparam logic [1:0] SENSE_RISE   = 2'h2;  // rising edge
   localparam logic [1:0] SENSE_BOTH   = 2'h3;  // both edges
   // =====================================================================
   // vectors and reset values
   localparam logic [7:0] VEC_NMI    = 8'h07;  // nmi vector number
   localparam logic [7:0] VEC_BASE   = 8'h10;  // vector of source 0
   localparam logic [2:0] PRI_RESET  = 3'h7;   // priority field reset
   localparam logic [2:0] SYS_RESET  = 3'h0;   // system control reset
endpackage : itr_pkg

// file: hw/itr_routing.sv
// itr_routing: interrupt priority and routing
// Operation
// - two control modes via mode select bits
// - eight priority levels per module group
// - nmi level 8, never masked
// - each source has its own vector
// - nmi edge selectable rising or falling
// - request lines: fall, rise, both, level
// - eight external and 52 internal sources
// - request during disabling instruction still taken
// - higher pending request wins, lower dropped
// - same delayed effect for flag clears
// - dma channel source picked by field
// - claimed source goes to dma only
// - transfer enable picks controller or cpu
// - select bit set: after transfer, clear enable, request cpu
// - count zero clears enable, requests cpu
// - transfer sources chosen by fixed order
// - transfer completes before cpu handling
// - dma handled independently of others
`timescale 1ns/1ps
`default_nettype none
module itr_routing
(
   input  wire  logic                          clk_i,            // 250 MHz
   input  wire  logic                          rst_b_i,          // async, low
   // avalon-mm slave
   input  wire  logic [7:0]                    address_i,        // byte address
   input  wire  logic                          read_i,           // read strobe
   input  wire  logic                          write_i,          // write strobe
   input  wire  logic [3:0]                    byteenable_i,     // lanes
   input  wire  logic [31:0]                   writedata_i,      // write data
   output var   logic [31:0]                   readdata_o,       // read data
   output var   logic                          waitrequest_o,    // stall
   // pins
   input  wire  logic                          nmi_pin_i,        // nmi pin
   input  wire  logic [itr_pkg::NUM_IRQ-1:0]   irq_pin_b_i,      // external_request_lines
   input  wire  logic [itr_pkg::NUM_INT-1:0]   int_src_i,        // internal requests
   // cpu core
   input  wire  logic                          cpu_mask_bit_i,   // mask bit
   input  wire  logic [2:0]                    cpu_mask_lvl_i,   // level mode mask
   input  wire  logic                          cpu_insn_busy_i,  // instruction running
   input  wire  logic                          cpu_ack_i,        // vector taken
   output var   logic                          cpu_irq_o,        // request to cpu
   output var   logic [7:0]                    cpu_vec_o,        // vector number
   // data_transfer_controller
   output var   logic                          dtc_req_o,        // activation
   output var   logic [5:0]                    dtc_src_o,        // source index
   input  wire  logic                          dtc_done_i,       // transfer ended
   input  wire  logic                          dtc_cpu_request_select_bit_i,      // cpu_request_select_bit
   input  wire  logic                          dtc_cnt_zero_i,   // count zero
   // dma_controller
   output var   logic [itr_pkg::NUM_DMA-1:0]   dma_req_o         // per channel source
);
   // =====================================================================
   // functions
   // byte enables to bit mask
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : be_mask

   // first highest-level request: {found, level, index}
   function automatic logic [9:0] pick(input logic [itr_pkg::NUM_SRC-1:0]   req,
                                       input logic [3*itr_pkg::NUM_SRC-1:0] lvl);
      logic       f;
      logic [2:0] b;
      logic [5:0] x;
      f = 1'b0;
      b = 3'h0;
      x = 6'h00;
      for (int i = 0; i < itr_pkg::NUM_SRC; i++)
      begin
         if (req[i] && (!f || lvl[3*i +: 3] > b))  // strict: lower index keeps ties
         begin
            f = 1'b1;
            b = lvl[3*i +: 3];
            x = 6'(i);
         end
      end
      return {f, b, x};
   endfunction : pick

   // =====================================================================
   // state
   logic [2:0]                  sys_q;        // system_control_reg
   logic [15:0]                 sense_q;      // two bits per request line
   logic [7:0]                  irq_en_q;     // line enables
   logic [7:0]                  irq_flag_q;   // edge flags
   logic [2:0]                  pri_q [itr_pkg::NUM_MOD];  // priority_level_regs
   logic [itr_pkg::NUM_SRC-1:0] ten_q;        // transfer_enable_regs
   logic [31:0]                 dmactl_q;     // dma_channel_control_reg set
   logic                        nmi_flag_q;   // pending nmi
   logic [1:0]                  nmi_sync_q;   // nmi synchroniser
   logic                        nmi_prev_q;   // nmi history
   logic [7:0]                  irq_s1_q;     // first sync stage
   logic [7:0]                  irq_s2_q;     // second sync stage
   logic [7:0]                  irq_prev_q;   // history for edges
   logic                        wait_q;       // waitrequest
   logic [31:0]                 rdata_q;      // read data
   logic                        hold_v_q;     // held request
   logic [5:0]                  hold_idx_q;   // its source
   logic [2:0]                  hold_lvl_q;   // its level
   logic                        cur_nmi_q;    // presented is nmi
   logic [5:0]                  cur_idx_q;    // presented source
   logic                        irq_q;        // cpu request
   logic [7:0]                  vec_q;        // cpu vector
   logic                        dtc_req_q;    // transfer request
   logic [5:0]                  dtc_src_q;    // transfer source
   logic [itr_pkg::NUM_DMA-1:0] dma_q;        // dma requests

   // =====================================================================
   // pin synchronisers and edge detection
   // two stages before use
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         nmi_sync_q <= 2'h0;
         nmi_prev_q <= 1'b0;
         irq_s1_q   <= 8'hFF;
         irq_s2_q   <= 8'hFF;
         irq_prev_q <= 8'hFF;
      end
      else
      begin
         nmi_sync_q <= {nmi_sync_q[0], nmi_pin_i};
         nmi_prev_q <= nmi_sync_q[1];
         irq_s1_q   <= irq_pin_b_i;
         irq_s2_q   <= irq_s1_q;
         irq_prev_q <= irq_s2_q;
      end
   end

   logic       nmi_edge;   // selected nmi edge seen
   logic [7:0] irq_edge;   // selected line edge seen
   logic [7:0] irq_lvl;    // line held low in level mode
   always_comb
   begin
      // nmi polarity select
      nmi_edge = sys_q[itr_pkg::SYS_NMI_RISE] ? (nmi_sync_q[1] & ~nmi_prev_q)
                                              : (~nmi_sync_q[1] & nmi_prev_q);
      for (int i = 0; i < itr_pkg::NUM_IRQ; i++)
      begin
         // per-line sense select
         case (sense_q[2*i +: 2])
            itr_pkg::SENSE_FALL: irq_edge[i] = ~irq_s2_q[i] & irq_prev_q[i];
            itr_pkg::SENSE_RISE: irq_edge[i] = irq_s2_q[i] & ~irq_prev_q[i];
            itr_pkg::SENSE_BOTH: irq_edge[i] = irq_s2_q[i] ^ irq_prev_q[i];
            default:             irq_edge[i] = 1'b0;
         endcase
         irq_lvl[i] = (sense_q[2*i +: 2] == itr_pkg::SENSE_LEVEL) & ~irq_s2_q[i];
      end
   end

   // =====================================================================
   // routing of requests
   logic [itr_pkg::NUM_SRC-1:0]   req_all;   // pending
   logic [itr_pkg::NUM_SRC-1:0]   claimed;   // dma owned
   logic [itr_pkg::NUM_SRC-1:0]   dtc_cand;  // transfer candidates
   logic [itr_pkg::NUM_SRC-1:0]   cpu_cand;  // cpu candidates
   logic [3*itr_pkg::NUM_SRC-1:0] lvl_flat;  // level per source
   logic [3*itr_pkg::NUM_SRC-1:0] lvl_zero;  // fixed order only
   logic [itr_pkg::NUM_DMA-1:0]   dma_sel;   // selected source per channel
   logic                          lvl_mode;  // level mode
   logic [9:0]                    live;      // best cpu request
   logic [9:0]                    dtc_pick;  // best transfer request
   always_comb
   begin
      // 8 lines plus 52 internal inputs
      req_all  = {int_src_i, (irq_flag_q | irq_lvl) & irq_en_q};
      claimed  = '0;
      lvl_zero = '0;
      // mode select from the two control bits
      lvl_mode = {sys_q[itr_pkg::SYS_MODE_HI], sys_q[itr_pkg::SYS_MODE_LO]} == itr_pkg::MODE_LEVEL;
      for (int c = 0; c < itr_pkg::NUM_DMA; c++)
      begin
         // source chosen by activation_source_field
         dma_sel[c] = req_all[itr_pkg::NUM_IRQ + int'(dmactl_q[c*itr_pkg::DMA_FLD_W +: 4])];
         if (dmactl_q[c*itr_pkg::DMA_FLD_W + itr_pkg::DMA_CLAIM])
            claimed[itr_pkg::NUM_IRQ + int'(dmactl_q[c*itr_pkg::DMA_FLD_W +: 4])] = 1'b1;
      end
      // claimed sources leave both other paths
      // transfer enable steers the rest
      dtc_cand = req_all & ten_q & ~claimed;
      cpu_cand = req_all & ~ten_q & ~claimed;
      if (dtc_req_q)
         cpu_cand[dtc_src_q] = 1'b0;  // transfer first, cpu after
      for (int i = 0; i < itr_pkg::NUM_SRC; i++)
      begin
         // group level, or fixed order
         lvl_flat[3*i +: 3] = lvl_mode ? pri_q[i / itr_pkg::SRC_PER_MOD] : 3'h0;
         if (lvl_mode ? (lvl_flat[3*i +: 3] <= cpu_mask_lvl_i) : cpu_mask_bit_i)
            cpu_cand[i] = 1'b0;
      end
      live     = pick(cpu_cand, lvl_flat);  // highest level, then order
      dtc_pick = pick(dtc_cand, lvl_zero);  // fixed order, no masks
   end

   // dma requests follow sources
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         dma_q <= '0;
      else
         dma_q <= dma_sel;
   end

   // =====================================================================
   // avalon-mm slave
   logic        wr_go;    // write takes effect
   logic [31:0] rd_word;  // addressed register
   logic [31:0] wmerge;   // merged write data
   logic [31:0] wbits;    // enabled write ones
   logic [31:0] pri_a;    // groups 0-7
   logic [31:0] pri_b;    // groups 8-14
   always_comb
   begin
      pri_a = '0;
      pri_b = '0;
      for (int m = 0; m < 8; m++)
         pri_a[m*itr_pkg::PRI_FLD_W +: 3] = pri_q[m];
      for (int m = 8; m < itr_pkg::NUM_MOD; m++)
         pri_b[(m-8)*itr_pkg::PRI_FLD_W +: 3] = pri_q[m];
      case ({address_i[7:2], 2'h0})
         itr_pkg::OFF_SYSCTL: rd_word = {29'h0, sys_q};
         itr_pkg::OFF_SENSE:  rd_word = {16'h0, sense_q};
         itr_pkg::OFF_IRQEN:  rd_word = {24'h0, irq_en_q};
         itr_pkg::OFF_IRQST:  rd_word = {23'h0, nmi_flag_q, irq_flag_q};
         itr_pkg::OFF_PRIA:   rd_word = pri_a;
         itr_pkg::OFF_PRIB:   rd_word = pri_b;
         itr_pkg::OFF_TENLO:  rd_word = ten_q[31:0];
         itr_pkg::OFF_TENHI:  rd_word = {4'h0, ten_q[59:32]};
         itr_pkg::OFF_DMACTL: rd_word = dmactl_q;
         itr_pkg::OFF_STATUS: rd_word = {12'h0, hold_v_q, irq_q, vec_q, 2'h0, dtc_req_q, 1'b0, dtc_src_q};
         default:             rd_word = 32'h0;  // unmapped reads zero
      endcase
      wbits  = writedata_i & be_mask(byteenable_i);
      wmerge = wbits | (rd_word & ~be_mask(byteenable_i));
      wr_go  = write_i & ~wait_q;
   end

   // one wait cycle, then answer
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0;
      end
      else if ((read_i | write_i) && wait_q)
      begin
         wait_q  <= 1'b0;
         rdata_q <= read_i ? rd_word : 32'h0;
      end
      else
         wait_q <= 1'b1;
   end

   // plain configuration registers
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sys_q    <= itr_pkg::SYS_RESET;
         sense_q  <= 16'h0;
         irq_en_q <= 8'h0;
         dmactl_q <= 32'h0;
         for (int m = 0; m < itr_pkg::NUM_MOD; m++)
            pri_q[m] <= itr_pkg::PRI_RESET;
      end
      else if (wr_go)
      begin
         case ({address_i[7:2], 2'h0})
            itr_pkg::OFF_SYSCTL: sys_q    <= wmerge[2:0];
            itr_pkg::OFF_SENSE:  sense_q  <= wmerge[15:0];
            itr_pkg::OFF_IRQEN:  irq_en_q <= wmerge[7:0];
            itr_pkg::OFF_DMACTL: dmactl_q <= wmerge;
            itr_pkg::OFF_PRIA:
               for (int m = 0; m < 8; m++)
                  pri_q[m] <= wmerge[m*itr_pkg::PRI_FLD_W +: 3];
            itr_pkg::OFF_PRIB:
               for (int m = 8; m < itr_pkg::NUM_MOD; m++)
                  pri_q[m] <= wmerge[(m-8)*itr_pkg::PRI_FLD_W +: 3];
            default: ;  // handled elsewhere
         endcase
      end
   end

   // =====================================================================
   // transfer enables and handshake
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ten_q     <= '0;
         dtc_req_q <= 1'b0;
         dtc_src_q <= 6'h00;
      end
      else
      begin
         if (wr_go && {address_i[7:2], 2'h0} == itr_pkg::OFF_TENLO)
            ten_q[31:0] <= wmerge;
         if (wr_go && {address_i[7:2], 2'h0} == itr_pkg::OFF_TENHI)
            ten_q[59:32] <= wmerge[27:0];
         if (dtc_req_q && dtc_done_i)
         begin
            dtc_req_q <= 1'b0;
            // select bit or zero count: source to cpu
            if (dtc_cpu_request_select_bit_i || dtc_cnt_zero_i)
               ten_q[dtc_src_q] <= 1'b0;
         end
         else if (!dtc_req_q && dtc_pick[9])
         begin
            dtc_req_q <= 1'b1;
            dtc_src_q <= dtc_pick[5:0];
         end
      end
   end

   // =====================================================================
   // source flags: set wins over clear
   logic [7:0] flag_clr;  // clears this cycle
   always_comb
   begin
      flag_clr = '0;
      if (wr_go && {address_i[7:2], 2'h0} == itr_pkg::OFF_IRQST)
         flag_clr = wbits[7:0];
      if (cpu_ack_i && irq_q && !cur_nmi_q && cur_idx_q < 6'd8)
         flag_clr[cur_idx_q[2:0]] = 1'b1;
      if (dtc_req_q && dtc_done_i && !dtc_cpu_request_select_bit_i && !dtc_cnt_zero_i && dtc_src_q < 6'd8)
         flag_clr[dtc_src_q[2:0]] = 1'b1;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         irq_flag_q <= 8'h0;
         nmi_flag_q <= 1'b0;
      end
      else
      begin
         irq_flag_q <= (irq_flag_q & ~flag_clr) | irq_edge;
         if (nmi_edge)
            nmi_flag_q <= 1'b1;
         else if (cpu_ack_i && irq_q && cur_nmi_q)
            nmi_flag_q <= 1'b0;
      end
   end

   // =====================================================================
   // cpu presentation
   // request seen mid-instruction kept for its end
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         hold_v_q   <= 1'b0;
         hold_idx_q <= 6'h00;
         hold_lvl_q <= 3'h0;
      end
      else if (cpu_ack_i && irq_q)
         hold_v_q <= 1'b0;  // taken, never presented twice
      else if (cpu_insn_busy_i)
      begin
         // clears act after the instruction
         if (live[9] && (!hold_v_q || live[8:6] > hold_lvl_q))
         begin
            hold_v_q   <= 1'b1;
            hold_idx_q <= live[5:0];
            hold_lvl_q <= live[8:6];
         end
      end
      else
         hold_v_q <= 1'b0;  // consumed
   end

   // nmi first, then held or live request
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         irq_q     <= 1'b0;
         vec_q     <= 8'h00;
         cur_nmi_q <= 1'b0;
         cur_idx_q <= 6'h00;
      end
      else if (cpu_ack_i && irq_q)
         irq_q <= 1'b0;  // taken
      else if (!cpu_insn_busy_i)
      begin
         if (nmi_flag_q)
         begin
            // nmi above all levels, ignores masks
            irq_q     <= 1'b1;
            cur_nmi_q <= 1'b1;
            vec_q     <= itr_pkg::VEC_NMI;
         end
         else if (hold_v_q && !(live[9] && live[8:6] > hold_lvl_q))
         begin
            irq_q     <= 1'b1;
            cur_nmi_q <= 1'b0;
            cur_idx_q <= hold_idx_q;
            vec_q     <= itr_pkg::VEC_BASE + {2'h0, hold_idx_q};
         end
         else
         begin
            irq_q     <= live[9];  // higher live request drops held one
            cur_nmi_q <= 1'b0;
            cur_idx_q <= live[5:0];
            vec_q     <= itr_pkg::VEC_BASE + {2'h0, live[5:0]};
         end
      end
   end

   // =====================================================================
   // outputs
   assign readdata_o    = rdata_q;
   assign waitrequest_o = wait_q;
   assign cpu_irq_o     = irq_q;
   assign cpu_vec_o     = vec_q;
   assign dtc_req_o     = dtc_req_q;
   assign dtc_src_o     = dtc_src_q;
   assign dma_req_o     = dma_q;
endmodule : itr_routing
`default_nettype wire

// file: tb/itr_sva.sv
// itr_sva: routing block assertions
`timescale 1ns/1ps
`default_nettype none
module itr_sva
(
   input wire logic       clk_i, rst_b_i, read_i, write_i, waitrequest_o, cpu_ack_i,
   input wire logic       cpu_insn_busy_i, cpu_irq_o, dtc_req_o, dtc_done_i,
   input wire logic [7:0] cpu_vec_o,
   input wire logic [5:0] dtc_src_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_WAIT_ONE: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("late bus answer");
   AST_WAIT_PULSE: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("long answer");
   AST_VEC_RANGE: assert property (cpu_irq_o |-> cpu_vec_o == 8'h07 || (cpu_vec_o >= 8'h10 && cpu_vec_o < 8'h4C))
      else $error("bad vector");
   AST_ACK_DROP: assert property (cpu_ack_i && cpu_irq_o |=> !cpu_irq_o)
      else $error("irq after ack");
   AST_FREEZE: assert property (cpu_insn_busy_i && !cpu_ack_i |=> $stable(cpu_irq_o) && $stable(cpu_vec_o))
      else $error("moved while busy");
   AST_DTC_HOLD: assert property (dtc_req_o && !dtc_done_i |=> dtc_req_o && $stable(dtc_src_o))
      else $error("early transfer drop");
   AST_DTC_DONE: assert property (dtc_req_o && dtc_done_i |=> !dtc_req_o)
      else $error("req after done");
   AST_DTC_SRC: assert property (dtc_req_o |-> dtc_src_o < 6'd60)
      else $error("bad source");
endmodule : itr_sva
`default_nettype wire

// file: tb/itr_far_model.sv
// itr_far_model: cpu and transfer engine model
`timescale 1ns/1ps
`default_nettype none
module itr_far_model
(
   input wire logic       clk_i, rst_b_i, cpu_irq_i, dtc_req_i, zsel_i,
   input wire logic [1:0] dly_i,
   output var logic       cpu_ack_o, dtc_done_o, dtc_cpu_request_select_bit_o, dtc_cnt_zero_o
);
   logic [1:0] cw_q, dw_q;  // delay counters
   // one of the two is always set
   assign dtc_cpu_request_select_bit_o    = zsel_i;
   assign dtc_cnt_zero_o = !zsel_i;
   // ack after dly_i cycles
   always_ff @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         cpu_ack_o <= 1'b0;
         cw_q      <= 2'h0;
      end
      else
      begin
         cpu_ack_o <= cpu_irq_i && !cpu_ack_o && cw_q >= dly_i;
         cw_q      <= (cpu_irq_i && !cpu_ack_o && cw_q < dly_i) ? cw_q + 2'h1 : 2'h0;
      end
   // done after dly_i cycles
   always_ff @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         dtc_done_o <= 1'b0;
         dw_q       <= 2'h0;
      end
      else
      begin
         dtc_done_o <= dtc_req_i && !dtc_done_o && dw_q >= dly_i;
         dw_q       <= (dtc_req_i && !dtc_done_o && dw_q < dly_i) ? dw_q + 2'h1 : 2'h0;
      end
endmodule : itr_far_model
`default_nettype wire

// file: tb/itr_routing_tb.sv
// itr_routing_tb: routing block bench
`timescale 1ns/1ps
`default_nettype none
module itr_routing_tb;
   logic clk_i = 0, rst_b_i = 0, read_i = 0, write_i = 0, nmi_pin_i = 0, zsel = 0;
   logic cpu_mask_bit_i = 0, cpu_insn_busy_i = 0;
   logic [7:0] address_i = 0, irq_pin_b_i = 8'hFF;
   logic [3:0] byteenable_i = 4'hF;
   logic [2:0] cpu_mask_lvl_i = 3'h0;
   logic [1:0] dly = 2'h0;
   logic [31:0] writedata_i = 0, r, d;
   logic [51:0] int_src_i = 0;
   logic [15:0] cm, p1, p2;
   wire logic [31:0] readdata_o;
   wire logic [7:0] cpu_vec_o;
   wire logic [5:0] dtc_src_o;
   wire logic [3:0] dma_req_o;
   wire logic waitrequest_o, cpu_irq_o, dtc_req_o, cpu_ack_i, dtc_done_i, dtc_cpu_request_select_bit_i, dtc_cnt_zero_i;
   int seed = 32'h35ce, n_errors = 0, num_checks = 0, a, b, k;
   logic [7:0] vq[$];  // expected vectors
   logic [5:0] dq[$];  // expected sources
   logic [31:0] msk[11] = '{32'h7, 32'hFFFF, 32'hFF, 32'h0, 32'h77777777, 32'h07777777,
                            32'hFFFFFFFF, 32'h0FFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0};
   itr_routing dut (.clk_i, .rst_b_i, .address_i, .read_i, .write_i, .byteenable_i, .writedata_i,
      .readdata_o, .waitrequest_o, .nmi_pin_i, .irq_pin_b_i, .int_src_i, .cpu_mask_bit_i, .cpu_mask_lvl_i,
      .cpu_insn_busy_i, .cpu_ack_i, .cpu_irq_o, .cpu_vec_o, .dtc_req_o, .dtc_src_o, .dtc_done_i,
      .dtc_cpu_request_select_bit_i, .dtc_cnt_zero_i, .dma_req_o);
   itr_far_model far (.clk_i, .rst_b_i, .cpu_irq_i(cpu_irq_o), .dtc_req_i(dtc_req_o), .zsel_i(zsel),
      .dly_i(dly), .cpu_ack_o(cpu_ack_i), .dtc_done_o(dtc_done_i), .dtc_cpu_request_select_bit_o(dtc_cpu_request_select_bit_i),
      .dtc_cnt_zero_o(dtc_cnt_zero_i));
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) cpu_insn_busy_i <= ($random(seed) & 3) == 0;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // one access, held to waitrequest low
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] q);
      int n = 0;
      address_i <= ad; writedata_i <= wd; write_i <= w; read_i <= !w;
      do begin @(posedge clk_i); n++; end while (waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) begin n_errors++; tally_and_finish; end
      q = readdata_o;
      read_i <= 1'b0; write_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   // drain queues, look for strays
   task automatic settle(input int t);
      int n = 0;
      while ((vq.size() || dq.size()) && n < 500) begin @(posedge clk_i); n++; end
      repeat (20) @(posedge clk_i);
      chk(vq.size() + dq.size(), 0);
      $display("test %0d done", t);
   endtask : settle
   // taken vectors and transfers vs expected queues
   always @(posedge clk_i) if (rst_b_i)
   begin
      if (cpu_ack_i && cpu_irq_o)
      begin
         chk(cpu_vec_o, vq.size() ? vq.pop_front() : 8'hFF);
         if (cpu_vec_o >= 8'h18) int_src_i[cpu_vec_o - 8'h18] <= 1'b0;
      end
      if (dtc_req_o && dtc_done_i) chk(dtc_src_o, dq.size() ? dq.pop_front() : 6'h3F);
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 11; i++) if (i != 9)
      begin
         bus(0, 8'(i * 4), 0, r);
         chk(r, i == 4 ? 32'h77777777 : i == 5 ? 32'h07777777 : 0);
         d = $random(seed);
         bus(1, 8'(i * 4), d, r);
         bus(0, 8'(i * 4), 0, r);
         chk(r, d & msk[i]);
      end
      for (int i = 2; i < 9; i++) bus(1, 8'(i * 4), 0, r);
      settle(1);
      for (int it = 0; it < 4; it++)
      begin
         a = $unsigned($random(seed)) % 7 + 1;
         b = $unsigned($random(seed)) % 7 + 1;
         bus(1, 8'h00, it == 3 ? 0 : 2, r);
         bus(1, 8'h10, 32'(a) << 8, r);
         bus(1, 8'h14, 32'(b) << 24, r);
         vq.push_back(it < 3 && b > a ? 8'h4B : 8'h18);
         vq.push_back(it < 3 && b > a ? 8'h18 : 8'h4B);
         int_src_i[0] <= 1'b1; int_src_i[51] <= 1'b1;
         settle(2);
      end
      cpu_mask_bit_i <= 1'b1;
      int_src_i[1] <= 1'b1;
      for (int e = 1; e >= 0; e--)
      begin
         bus(1, 8'h00, 32'(e) << 2, r);
         vq.push_back(8'h07);
         nmi_pin_i <= e[0];
         repeat (30) @(posedge clk_i);
      end
      vq.push_back(8'h19);
      cpu_mask_bit_i <= 1'b0;
      settle(3);
      bus(1, 8'h08, 32'hFF, r);
      for (int m = 1; m < 4; m++)
      begin
         k = $unsigned($random(seed)) % 8;
         bus(1, 8'h04, 32'(m) << (2 * k), r);
         repeat (m == 3 ? 2 : 1) vq.push_back(8'(16 + k));
         irq_pin_b_i[k] <= 1'b0;
         repeat (30) @(posedge clk_i);
         irq_pin_b_i[k] <= 1'b1;
         settle(4);
      end
      for (int it = 0; it < 6; it++)
      begin
         a = 8 + $unsigned($random(seed)) % 51;
         b = a + 1 + $unsigned($random(seed)) % (59 - a);
         zsel <= $random(seed); dly <= $random(seed);
         bus(1, 8'h18, 32'hFFFFFFFF, r);
         bus(1, 8'h1C, 32'h0FFFFFFF, r);
         dq.push_back(6'(a)); dq.push_back(6'(b));
         vq.push_back(8'(16 + a)); vq.push_back(8'(16 + b));
         cpu_mask_bit_i <= 1'b1;
         int_src_i[a - 8] <= 1'b1; int_src_i[b - 8] <= 1'b1;
         repeat (60) @(posedge clk_i);
         cpu_mask_bit_i <= 1'b0;
         settle(5);
      end
      d = $random(seed) & 32'h0F0F0F0F | 32'h10101010;
      bus(1, 8'h20, d, r);
      cm = 0; p1 = 0; p2 = 0;
      for (int c = 0; c < 4; c++) cm[d[8 * c +: 4]] = 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         for (int c = 0; c < 4; c++) chk(dma_req_o[c], p2[d[8 * c +: 4]]);
         p2 = p1;
         p1 = 16'($random(seed)) & cm;
         int_src_i[15:0] <= p1;
         @(posedge clk_i);
      end
      int_src_i[15:0] <= 16'h0;
      settle(6);
      tally_and_finish;
   end
   // watchdog at 50000 cycles, several times the longest run
   initial
   begin
      #200000;
      n_errors++;
      tally_and_finish;
   end
endmodule : itr_routing_tb
bind itr_routing itr_sva u_sva (.clk_i, .rst_b_i, .read_i, .write_i, .waitrequest_o, .cpu_ack_i,
   .cpu_insn_busy_i, .cpu_irq_o, .dtc_req_o, .dtc_done_i, .cpu_vec_o, .dtc_src_o);
`default_nettype wire
